/* File: include/sntl_pkg.sv */
package sntl_pkg;
  // ==========================================================
  // Register map (byte addresses), control fields and status bit positions.
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_TICK = 5'h08;
  localparam logic [4:0] OFS_FRAME = 5'h0c;
  localparam logic [4:0] OFS_DATL = 5'h10;
  localparam logic [4:0] OFS_DATH = 5'h14;
  localparam logic [4:0] OFS_SYNC = 5'h18;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hafd7;
  localparam int B_EN = 15;
  localparam int B_ISTOP = 13;
  localparam int B_RX = 11;
  localparam int B_TXM = 10;
  localparam int B_POL = 9;
  localparam int B_CRC = 8;
  localparam int B_PPP = 7;
  localparam int B_SPC = 6;
  localparam int B_PS = 4;
  localparam int B_FRM = 2;
  localparam int B_CRCE = 3;
  localparam int B_GO = 0;
  // ==========================================================
  // Frame timing in ticks, prescaler limit and CRC constants.
  localparam logic [5:0] SYNC_TICKS = 6'h38;
  localparam logic [5:0] NIB_BASE = 6'h0c;
  localparam logic [5:0] NIB_TOP = 6'h1b;
  localparam logic [5:0] PAUSE_MIN = 6'h0c;
  localparam logic [5:0] LOW_TICKS = 6'h05;
  localparam logic [11:0] FRAME_CAP = 12'h7ff;
  localparam logic [1:0] PRE_DIV4 = 2'h3;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hd;
  // ==========================================================
  // State encodings.
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEG = 3'b010, TX_PAUSE = 3'b100} sntl_tx_t;
  typedef enum logic [2:0] {RX_HUNT = 3'b001, RX_NIB = 3'b010, RX_SKIP = 3'b100} sntl_rx_t;
endpackage : sntl_pkg

/* File: verilog/sntl_link.sv */
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
module sntl_link (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_sent_in,
  output logic o_sent_out,
  input wire logic i_idle_mode,
  output logic o_frame_done,
  output logic o_spc_enable
);
  import sntl_pkg::*;

  // ==========================================================
  // Shared helpers.
  // J2716 CRC over the selected data nibbles, augmented by a zero nibble.
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] d);
    logic [3:0] r;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      // Data bits enter at the bottom, which is the nibble table form.
      if (r[3]) begin
        r = {r[2:0], d[b]} ^ CRC_POLY;
      end else begin
        r = {r[2:0], d[b]};
      end
    end
    return r;
  endfunction : crc_step

  function automatic logic [3:0] crc_calc(input logic [31:0] w, input logic [2:0] n);
    logic [3:0] c;
    c = CRC_SEED;
    for (int k = 1; k <= 6; k++) begin
      if (k <= int'(n)) begin
        c = crc_step(c, w[31-4*k -: 4]);
      end
    end
    return crc_step(c, 4'h0);
  endfunction : crc_calc

  // ==========================================================
  // State declarations.
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [15:0] ctrl, next_ctrl;
  logic [15:0] tick_lim, next_tick_lim;
  logic [15:0] frame_lim, next_frame_lim;
  logic [15:0] datl, next_datl;
  logic [15:0] dath, next_dath;
  logic [15:0] sync_cap, next_sync_cap;
  logic go, next_go;
  logic frm_err, next_frm_err;
  logic crc_err, next_crc_err;
  logic done_q, spc_q;
  logic [1:0] pre_cnt, next_pre_cnt;
  logic [15:0] tick_cnt, next_tick_cnt;
  sntl_tx_t tx_st, next_tx_st;
  logic [3:0] seg, next_seg;
  logic [5:0] seg_el, next_seg_el;
  logic [11:0] frame_tk, next_frame_tk;
  logic line_q, next_line_q;
  logic sin_s1, sin_s2, sin_d;
  sntl_rx_t rx_st, next_rx_st;
  logic [3:0] rx_idx, next_rx_idx;
  logic [15:0] per_cnt, next_per_cnt;
  logic [16:0] acc, next_acc;
  logic [5:0] rx_tk, next_rx_tk;

  logic en, rx_mode, run, pre_en, tick, fall;
  logic [2:0] nib_n;
  logic [3:0] crc_seg;
  logic [31:0] tx_word;
  logic [3:0] tx_nib, rx_crc_calc;
  logic [5:0] seg_len;
  logic [11:0] frame_goal;
  logic tx_done, tx_start, rx_done, rx_bad, rx_sync_ok, rx_idle;
  logic [2:0] nib_stat;
  logic [15:0] stat;
  logic [15:0] wmask;
  logic wr;

  // ==========================================================
  // Common decode.
  assign en = ctrl[B_EN];
  assign rx_mode = ctrl[B_RX];
  assign run = en & ~(ctrl[B_ISTOP] & i_idle_mode);
  // Reserved counts fold onto the nearest legal length.
  assign nib_n = (ctrl[2:0] == 3'h0) ? 3'h1 : ((ctrl[2:0] == 3'h7) ? 3'h6 : ctrl[2:0]);
  assign crc_seg = {1'b0, nib_n} + 4'h2;
  assign pre_en = run & (~ctrl[B_PS] | (pre_cnt == PRE_DIV4));
  assign tick = pre_en & (tick_cnt == tick_lim);
  assign fall = sin_d & ~sin_s2;
  assign wr = i_write & ack;
  assign wmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  // ==========================================================
  // Bus handshake: one wait state, answer registered.
  assign o_waitrequest = (i_read | i_write) & ~ack;
  assign o_readdata = rdata;
  assign o_frame_done = done_q;
  assign o_spc_enable = spc_q;
  assign o_sent_out = line_q;

  // ==========================================================
  // Transmit frame content with hardware CRC substituted when enabled.
  always_comb begin
    tx_word = {dath, datl};
    if (ctrl[B_CRC]) begin
      tx_word[3:0] = crc_calc({dath, datl}, nib_n);
    end
    if (seg == crc_seg) begin
      tx_nib = tx_word[3:0];
    end else begin
      tx_nib = tx_word[31-4*(32'(seg)-1) -: 4];
    end
    if (seg == 4'h0) begin
      seg_len = SYNC_TICKS;
    end else begin
      seg_len = NIB_BASE + {2'h0, tx_nib};
    end
    frame_goal = 12'h0;
    if (!ctrl[B_TXM]) begin
      frame_goal = (frame_lim > 16'(FRAME_CAP)) ? FRAME_CAP : frame_lim[11:0];
    end
  end

  // ==========================================================
  // Receive side helpers: CRC over received words, idle detect.
  assign rx_crc_calc = crc_calc({dath, datl}, nib_n);
  assign rx_idle = rx_mode & sin_s2 & (per_cnt >= tick_lim);

  // Status word; nibble index follows the active direction.
  always_comb begin
    nib_stat = 3'h0;
    if (rx_mode) begin
      if (rx_st == RX_NIB) begin
        nib_stat = (rx_idx == crc_seg - 4'h1) ? 3'h7 : rx_idx[2:0];
      end
    end else if (tx_st == TX_SEG && seg >= 4'h2) begin
      nib_stat = (seg == crc_seg) ? 3'h7 : 3'(seg - 4'h1);
    end
    stat = 16'h0;
    stat[7] = rx_mode ? (rx_st == RX_SKIP) : (tx_st == TX_PAUSE);
    stat[6:4] = nib_stat;
    stat[B_CRCE] = crc_err;
    stat[B_FRM] = frm_err;
    stat[1] = rx_idle;
    if (rx_mode) begin
      stat[B_GO] = (rx_st != RX_HUNT);
    end else begin
      stat[B_GO] = ctrl[B_TXM] ? go : en;
    end
  end

  // ==========================================================
  // Transmitter: tick divider, segment sequencer, line driver.
  // The line leaves its idle level for a few ticks at each segment start; the
  // receiver keys only on the falling edges.
  always_comb begin
    next_pre_cnt = run ? pre_cnt + 2'h1 : pre_cnt;
    next_tick_cnt = tick_cnt;
    if (pre_en) begin
      next_tick_cnt = (tick_cnt == tick_lim) ? 16'h0 : tick_cnt + 16'h1;
    end
    next_tx_st = tx_st;
    next_seg = seg;
    next_seg_el = seg_el;
    next_frame_tk = frame_tk;
    tx_done = 1'b0;
    // Triggered mode waits for the go flag, continuous mode just runs.
    tx_start = en & ~rx_mode & (~ctrl[B_TXM] | go);
    case (tx_st)
      TX_IDLE: begin
        if (run & tx_start) begin
          next_tx_st = TX_SEG;
          next_seg = 4'h0;
          next_seg_el = 6'h0;
          next_frame_tk = 12'h0;
          next_tick_cnt = 16'h0;
          // Restarting the prescaler keeps the first tick of a frame full length.
          next_pre_cnt = 2'h0;
        end
      end
      TX_SEG: begin
        if (tick) begin
          next_frame_tk = (frame_tk == 12'hfff) ? frame_tk : frame_tk + 12'h1;
          next_seg_el = seg_el + 6'h1;
          if (seg_el + 6'h1 >= seg_len) begin
            next_seg_el = 6'h0;
            next_seg = seg + 4'h1;
            if (seg == crc_seg) begin
              tx_done = 1'b1;
              if (ctrl[B_PPP]) begin
                next_tx_st = TX_PAUSE;
              end else if (!ctrl[B_TXM]) begin
                next_seg = 4'h0;
                next_frame_tk = 12'h0;
              end else begin
                next_tx_st = TX_IDLE;
              end
            end
          end
        end
      end
      TX_PAUSE: begin
        if (tick) begin
          next_frame_tk = (frame_tk == 12'hfff) ? frame_tk : frame_tk + 12'h1;
          next_seg_el = (seg_el == 6'h3f) ? seg_el : seg_el + 6'h1;
          // Pause holds at least its floor, then until the frame goal.
          // Compare seg_el without adding, since the saturated count would wrap.
          if (seg_el >= PAUSE_MIN - 6'h1 && frame_tk + 12'h1 >= frame_goal) begin
            next_seg_el = 6'h0;
            next_seg = 4'h0;
            next_frame_tk = 12'h0;
            next_tx_st = ctrl[B_TXM] ? TX_IDLE : TX_SEG;
          end
        end
      end
      default: next_tx_st = TX_IDLE;
    endcase
    if (!en || rx_mode) begin
      next_tx_st = TX_IDLE;
    end
    // Line leaves its idle level only in the opening ticks of a segment; idle is high, or low with B_POL set.
    next_line_q = ctrl[B_POL] ^ ~((tx_st != TX_IDLE) & (seg_el < LOW_TICKS));
    if (rx_mode) begin
      next_line_q = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt <= 2'h0;
      tick_cnt <= 16'h0;
      tx_st <= TX_IDLE;
      seg <= 4'h0;
      seg_el <= 6'h0;
      frame_tk <= 12'h0;
      line_q <= 1'b1;
    end else begin
      pre_cnt <= next_pre_cnt;
      tick_cnt <= next_tick_cnt;
      tx_st <= next_tx_st;
      seg <= next_seg;
      seg_el <= next_seg_el;
      frame_tk <= next_frame_tk;
      line_q <= next_line_q;
    end
  end

  // ==========================================================
  // Receiver: times falling-edge intervals and scales them to ticks
  // with an accumulator, which avoids a divider at the cost of one
  // count of rounding error per interval.
  always_comb begin
    next_rx_st = rx_st;
    next_rx_idx = rx_idx;
    next_per_cnt = per_cnt;
    next_acc = acc;
    next_rx_tk = rx_tk;
    rx_done = 1'b0;
    rx_bad = 1'b0;
    rx_sync_ok = 1'b0;
    if (pre_en) begin
      next_per_cnt = (per_cnt == 16'hffff) ? per_cnt : per_cnt + 16'h1;
      if (acc + 17'(SYNC_TICKS) >= {1'b0, sync_cap}) begin
        next_acc = acc + 17'(SYNC_TICKS) - {1'b0, sync_cap};
        next_rx_tk = (rx_tk == 6'h3f) ? rx_tk : rx_tk + 6'h1;
      end else begin
        next_acc = acc + 17'(SYNC_TICKS);
      end
    end
    if (run && rx_mode && fall) begin
      // The fall edge itself counts, so N prescaled clocks read as N.
      next_per_cnt = pre_en ? 16'h1 : 16'h0;
      next_rx_tk = 6'h0;
      next_acc = {2'h0, sync_cap[15:1]};
      case (rx_st)
        RX_HUNT: begin
          if (per_cnt >= frame_lim && per_cnt <= tick_lim) begin
            rx_sync_ok = 1'b1;
            next_acc = {2'h0, per_cnt[15:1]};
            next_rx_st = RX_NIB;
            next_rx_idx = 4'h0;
          end
        end
        RX_NIB: begin
          if (rx_tk < NIB_BASE || rx_tk > NIB_TOP) begin
            rx_bad = 1'b1;
            next_rx_st = RX_HUNT;
          end else if (rx_idx == crc_seg - 4'h1) begin
            rx_done = 1'b1;
            next_rx_st = ctrl[B_PPP] ? RX_SKIP : RX_HUNT;
          end else begin
            next_rx_idx = rx_idx + 4'h1;
          end
        end
        RX_SKIP: next_rx_st = RX_HUNT;
        default: next_rx_st = RX_HUNT;
      endcase
    end
    if (!en || !rx_mode) begin
      next_rx_st = RX_HUNT;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
      sin_d <= 1'b1;
      rx_st <= RX_HUNT;
      rx_idx <= 4'h0;
      per_cnt <= 16'h0;
      acc <= 17'h0;
      rx_tk <= 6'h0;
    end else begin
      sin_s1 <= i_sent_in;
      sin_s2 <= sin_s1;
      sin_d <= sin_s2;
      rx_st <= next_rx_st;
      rx_idx <= next_rx_idx;
      per_cnt <= next_per_cnt;
      acc <= next_acc;
      rx_tk <= next_rx_tk;
    end
  end

  // ==========================================================
  // Register file and bus answer. Hardware sets of the sticky flags
  // win over a software clear landing in the same cycle.
  always_comb begin
    logic [3:0] nv;
    nv = rx_tk[3:0] - NIB_BASE[3:0];
    next_ack = (i_read | i_write) & ~ack;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_tick_lim = tick_lim;
    next_frame_lim = frame_lim;
    next_datl = datl;
    next_dath = dath;
    next_sync_cap = sync_cap;
    next_go = go;
    next_frm_err = frm_err;
    next_crc_err = crc_err;
    if (wr) begin
      case (i_address)
        OFS_CTRL: next_ctrl = (ctrl & ~(wmask & CTRL_WMASK)) | (i_writedata[15:0] & wmask & CTRL_WMASK);
        OFS_TICK: next_tick_lim = (tick_lim & ~wmask) | (i_writedata[15:0] & wmask);
        OFS_FRAME: next_frame_lim = (frame_lim & ~wmask) | (i_writedata[15:0] & wmask);
        OFS_STAT: begin
          if (i_byteenable[0]) begin
            next_frm_err = frm_err & i_writedata[B_FRM];
            next_crc_err = crc_err & i_writedata[B_CRCE];
            if (!rx_mode && i_writedata[B_GO]) begin
              next_go = 1'b1;
            end
          end
        end
        OFS_DATL: begin
          if (!rx_mode) begin
            next_datl = (datl & ~(wmask & {12'hfff, {4{~ctrl[B_CRC]}}})) |
                        (i_writedata[15:0] & wmask & {12'hfff, {4{~ctrl[B_CRC]}}});
          end
        end
        OFS_DATH: begin
          if (!rx_mode) begin
            next_dath = (dath & ~wmask) | (i_writedata[15:0] & wmask);
          end
        end
        default: next_rdata = rdata;
      endcase
    end
    // Triggered transmit clears its go flag when the frame ends.
    if (tx_done && ctrl[B_TXM] && !(wr && i_address == OFS_STAT && i_byteenable[0] && i_writedata[B_GO])) begin
      next_go = 1'b0;
    end
    if (rx_sync_ok) begin
      next_sync_cap = per_cnt;
    end
    if (run && rx_mode && fall && rx_st == RX_NIB && !rx_bad) begin
      if (rx_idx == crc_seg - 4'h1) begin
        next_datl[3:0] = nv;
      end else if (rx_idx < 4'h4) begin
        next_dath[15-4*rx_idx[1:0] -: 4] = nv;
      end else begin
        next_datl[15-4*(rx_idx[1:0]) -: 4] = nv;
      end
    end
    if (rx_bad) begin
      next_frm_err = 1'b1;
    end
    if (rx_done && ctrl[B_CRC] && rx_crc_calc != nv) begin
      next_crc_err = 1'b1;
    end
    if (next_ack && i_read) begin
      case (i_address)
        OFS_CTRL: next_rdata = {16'h0, ctrl};
        OFS_STAT: next_rdata = {16'h0, stat};
        OFS_TICK: next_rdata = {16'h0, tick_lim};
        OFS_FRAME: next_rdata = {16'h0, frame_lim};
        OFS_DATL: next_rdata = {16'h0, tx_word[15:0]};
        OFS_DATH: next_rdata = {16'h0, dath};
        OFS_SYNC: next_rdata = {16'h0, sync_cap};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      ctrl <= CTRL_RESET;
      tick_lim <= 16'h0;
      frame_lim <= 16'h0;
      datl <= 16'h0;
      dath <= 16'h0;
      sync_cap <= 16'h0;
      go <= 1'b0;
      frm_err <= 1'b0;
      crc_err <= 1'b0;
      done_q <= 1'b0;
      spc_q <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      tick_lim <= next_tick_lim;
      frame_lim <= next_frame_lim;
      datl <= next_datl;
      dath <= next_dath;
      sync_cap <= next_sync_cap;
      go <= next_go;
      frm_err <= next_frm_err;
      crc_err <= next_crc_err;
      done_q <= tx_done | rx_done;
      spc_q <= en & rx_mode & ctrl[B_SPC];
    end
  end
endmodule : sntl_link

/* File: bench/sntl_link_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// Port-level checks on the bus handshake and the line shape.
module sntl_link_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_sent_out,
  input wire logic o_frame_done,
  input wire logic o_spc_enable
);
  import sntl_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // The slave always inserts exactly one wait state.
  wait_one_a: assert property ($rose(i_read | i_write) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("bus answer not after one wait state");
  bus_quiet_a: assert property (!(i_read || i_write) |-> !o_waitrequest)
    else $error("wait request without a request");
  unmapped_zero_a: assert property (i_read && !o_waitrequest && i_address > OFS_SYNC |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Read data only move at the edge that starts a read answer.
  read_hold_a: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
    else $error("read data moved between answers");
  spc_level_a: assert property (
    i_write && !o_waitrequest && i_address == OFS_CTRL && i_byteenable[1:0] == 2'h3
    |-> ##2 o_spc_enable == $past(i_writedata[15] & i_writedata[11] & i_writedata[6], 2))
    else $error("short code enable does not follow control");
  done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
    else $error("completion pulse longer than one cycle");
  // Every segment opens with five ticks low, or high with B_POL set, so no low is shorter than five cycles.
  low_min_a: assert property ($fell(o_sent_out) |-> !o_sent_out[*5])
    else $error("low phase shorter than five cycles");
  high_min_a: assert property ($rose(o_sent_out) |-> o_sent_out[*7])
    else $error("high phase shorter than seven cycles");
  rx_quiet_a: assert property (o_spc_enable |-> o_sent_out)
    else $error("line driven while receiving");
endmodule : sntl_link_checker

bind sntl_link sntl_link_checker u_sntl_link_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_sent_out(o_sent_out), .o_frame_done(o_frame_done), .o_spc_enable(o_spc_enable));

/* File: bench/sntl_sensor_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-side sensor; the line idles high as with a pull-up.
module sntl_sensor_model (
  input wire logic i_clk,
  output logic o_line
);
  initial o_line = 1'b1;
  // One segment: five ticks low, then high for the rest.
  task automatic seg(input int tk, input int t);
    repeat (5 * tk) @(posedge i_clk) o_line <= 1'b0;
    repeat ((t - 5) * tk) @(posedge i_clk) o_line <= 1'b1;
  endtask : seg
  // Sync, status, n data, CRC, then a closing fall; nibble bad lasts 28 ticks.
  task automatic send(input int tk, input logic [31:0] nib, input int n, input int bad);
    seg(tk, 56);
    for (int i = 0; i < n + 2; i++) seg(tk, i == bad ? 28 : 12 + nib[31 - 4 * i -: 4]);
    seg(tk, 12);
  endtask : send
endmodule : sntl_sensor_model

/* File: bench/test_sntl_link.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench: registers, transmit and receive frames.
module test_sntl_link;
  import sntl_pkg::*;
  localparam logic [31:0] NIBS = 32'h5a3c9e17;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'h3;
  logic i_idle_mode = 1'b0;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_sent_out, o_frame_done, o_spc_enable, line;
  logic pol = 1'b0;
  logic prev = 1'b1;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int cnt = 0;
  int done_n = 0;
  int q[$];
  int e[10];

  sntl_link u_sntl_link (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_sent_in(line), .o_sent_out(o_sent_out), .i_idle_mode(i_idle_mode),
    .o_frame_done(o_frame_done), .o_spc_enable(o_spc_enable));
  sntl_sensor_model u_sntl_sensor_model (.i_clk(i_clk), .o_line(line));

  // 40 MHz clock.
  always #12.5 i_clk = ~i_clk;

  // Fall-to-fall intervals with polarity removed, completion count, run ceiling.
  always @(posedge i_clk) begin
    prev <= o_sent_out ^ pol;
    cnt <= cnt + 1;
    if (prev && !(o_sent_out ^ pol)) begin
      q.push_back(cnt);
      cnt <= 1;
    end
    if (o_frame_done === 1'b1) done_n++;
    cycles++;
    if (cycles > 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus cycle; the request stands until wait request is sampled low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [31:0] r);
    @(posedge i_clk);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= {16'h0000, d};
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    r = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] x, input string what);
    logic [31:0] r;
    bus(1'b0, a, 16'h0, r);
    chk(what, r & m, x);
  endtask : rd

  // Check nibble over data nibbles only, seed 5, augmented by one zero nibble.
  function automatic logic [3:0] crc4(input logic [31:0] d, input int n);
    logic [3:0] c;
    c = 4'h5;
    for (int i = 0; i < 4 * n + 4; i++) c = {c[2:0], i < 4 * n ? d[27 - i] : 1'b0} ^ (c[3] ? 4'hd : 4'h0);
    return c;
  endfunction : crc4

  // Expected ticks: sync, status, data, CRC, then the pause that fills the frame.
  function automatic void fill(input int n, input logic [3:0] cr, input int frm);
    int used;
    used = 0;
    for (int k = 0; k < n + 3; k++) begin
      e[k] = k == 0 ? 56 : k == n + 2 ? 12 + cr : 12 + NIBS[31 - 4 * (k - 1) -: 4];
      used += e[k];
    end
    e[n + 3] = (frm > 2047 ? 2047 : frm) - used;
    if (e[n + 3] < 12) e[n + 3] = 12;
  endfunction : fill

  task automatic reg_check();
    rd(OFS_CTRL, 32'hffffffff, 32'h0, "control reset");
    wr(OFS_CTRL, 16'hffff);
    rd(OFS_CTRL, 32'hffffffff, 32'h0000afd7, "control bits");
    wr(OFS_CTRL, 16'h0000);
    wr(5'h1c, 16'hffff);
    rd(5'h1c, 32'hffffffff, 32'h0, "unmapped");
  endtask : reg_check

  // Continuous frames with pause; configure first, enable last.
  task automatic tx_run(input logic [15:0] cfg, input logic [15:0] tick, input int frm);
    int n;
    int c;
    n = cfg[2:0];
    c = (tick + 1) * (cfg[B_PS] ? 4 : 1);
    pol = cfg[B_POL];
    wr(OFS_CTRL, cfg);
    wr(OFS_TICK, tick);
    wr(OFS_FRAME, frm[15:0]);
    wr(OFS_DATH, NIBS[31:16]);
    wr(OFS_DATL, NIBS[15:0]);
    chk("idle level", o_sent_out, !cfg[B_POL]);
    wr(OFS_CTRL, cfg | 16'h8000);
    q.delete();
    fill(n, cfg[B_CRC] ? crc4(NIBS, n) : NIBS[3:0], frm);
    while (q.size() < n + 5) @(posedge i_clk);
    for (int k = 0; k < n + 4; k++) chk("tx interval", q[k + 1], e[k] * c);
    // Stop only after the next sync's low phase, so no short pulse is cut.
    repeat (5 * c + 2) @(posedge i_clk);
    wr(OFS_CTRL, 16'h0000);
    pol = 1'b0;
  endtask : tx_run

  task automatic tx_trig();
    wr(OFS_CTRL, 16'h8502);
    q.delete();
    repeat (100) @(posedge i_clk);
    chk("untriggered falls", q.size(), 0);
    done_n = 0;
    wr(OFS_STAT, 16'h0001);
    rd(OFS_STAT, 32'h1, 32'h1, "go flag");
    while (done_n == 0) @(posedge i_clk);
    fill(2, 4'h0, 0);
    for (int k = 0; k < 4; k++) chk("trig interval", q[k + 1], e[k]);
    repeat (20) @(posedge i_clk);
    rd(OFS_STAT, 32'h1, 32'h0, "go flag");
    chk("single frame", done_n, 1);
    wr(OFS_CTRL, 16'h0000);
  endtask : tx_trig

  task automatic idle_halt();
    i_idle_mode <= 1'b1;
    wr(OFS_CTRL, 16'ha001);
    q.delete();
    repeat (200) @(posedge i_clk);
    chk("halted falls", q.size(), 0);
    done_n = 0;
    wr(OFS_CTRL, 16'h8001);
    while (done_n == 0) @(posedge i_clk);
    repeat (8) @(posedge i_clk);
    wr(OFS_CTRL, 16'h0000);
    i_idle_mode <= 1'b0;
  endtask : idle_halt

  // Receive at 4 clocks per tick: sync is 224, limits 179 and 268.
  task automatic rx_run();
    logic [31:0] good;
    good = {NIBS[31:4], crc4(NIBS, 6)};
    wr(OFS_CTRL, 16'h0846);
    wr(OFS_TICK, 16'd268);
    wr(OFS_FRAME, 16'd179);
    wr(OFS_CTRL, 16'h8846);
    done_n = 0;
    u_sntl_sensor_model.send(6, NIBS, 6, 99);
    chk("slow sync frames", done_n, 0);
    u_sntl_sensor_model.send(4, NIBS, 6, 99);
    chk("frames", done_n, 1);
    rd(OFS_DATH, 32'hffff, NIBS[31:16], "data high");
    rd(OFS_DATL, 32'hffff, NIBS[15:0], "data low");
    rd(OFS_SYNC, 32'hffff, 32'd224, "sync time");
    wr(OFS_DATL, 16'h0000);
    rd(OFS_DATL, 32'hffff, NIBS[15:0], "data low");
    u_sntl_sensor_model.send(4, NIBS, 6, 3);
    rd(OFS_STAT, 32'h4, 32'h4, "framing");
    chk("frames", done_n, 1);
    wr(OFS_STAT, 16'h0000);
    rd(OFS_STAT, 32'h4, 32'h0, "framing");
    wr(OFS_CTRL, 16'h8946);
    u_sntl_sensor_model.send(4, good, 6, 99);
    rd(OFS_STAT, 32'hc, 32'h0, "crc fault");
    u_sntl_sensor_model.send(4, good ^ 32'h1, 6, 99);
    rd(OFS_STAT, 32'h8, 32'h8, "crc fault");
    chk("frames", done_n, 3);
    wr(OFS_CTRL, 16'h0000);
  endtask : rx_run

  // Main sequence.
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    reg_check();
    tx_run(16'h0181, 16'h0001, 860);
    tx_run(16'h0296, 16'h0000, 1000);
    tx_run(16'h0183, 16'h0000, 65535);
    tx_trig();
    idle_halt();
    rx_run();
    tally_and_finish();
  end
endmodule : test_sntl_link
